//--- bench/imc_top_test.sv
// Self-checking testbench of the interrupt mask block
`timescale 1ns/1ps
`include "imc_map.svh"

module imc_top_test;
	import imc_pkg::*;

	logic                   clock_i;
	logic                   nrst_i;
	logic                   soft_reset_i;
	imc_bus_req_type        bus_i;
	imc_event_type          event_i;
	logic [`IMC_DATA_W-1:0] rdata_o;
	logic                   irq_o;
	logic [`IMC_DATA_W-1:0] mask_o;
	int                     miscompares;
	int                     samples_checked;

	imc_top i_imc_top (
		.clock_i      (clock_i),
		.nrst_i       (nrst_i),
		.soft_reset_i (soft_reset_i),
		.bus_i        (bus_i),
		.rdata_o      (rdata_o),
		.event_i      (event_i),
		.irq_o        (irq_o),
		.mask_o       (mask_o)
	);

	// Clock at 200 MHz
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Word compare
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Flag compare
	task automatic chk1(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// One-cycle write, optionally judging the interrupt inside the write cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit chk = 1'b0, input logic exp = 1'b0);
		@(posedge clock_i);
		bus_i <= '{a, d, 1'b1, 1'b0};
		#1;
		if (chk) chk1(irq_o, exp, "irq in write cycle");
		@(posedge clock_i);
		bus_i <= '0;
		#1;
	endtask

	// One-cycle read; data stand only in the following cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		bus_i <= '{a, 32'h00000000, 1'b0, 1'b1};
		@(posedge clock_i);
		bus_i <= '0;
		#1;
		chk32(rdata_o, exp, "read data");
		@(posedge clock_i);
		#1;
		chk32(rdata_o, `IMC_READ_ZERO, "read data after its cycle");
	endtask

	// One-cycle event pulse
	task automatic pulse(input imc_event_type ev);
		@(posedge clock_i);
		event_i <= ev;
		@(posedge clock_i);
		event_i <= '0;
		#1;
	endtask

	// Reset values and offset of the clear port
	task automatic test_reset;
		chk32(mask_o, `IMC_MASK_RESET, "mask after reset");
		chk1(irq_o, 1'b0, "irq after reset");
		rd(`IMC_OFS_MASK_CLR, `IMC_MASK_RESET);
		$display("test_reset done");
	endtask

	// Each clear bit clears only its own mask bit
	task automatic test_clear_bits;
		int          bits[9] = '{31, 30, 6, 5, 4, 3, 2, 1, 0};
		logic [31:0] exp;
		wr(`IMC_OFS_MASK_SET, 32'hFFFFFFFF);
		exp = `IMC_MASK_BITS;
		chk32(mask_o, exp, "mask after set");
		foreach (bits[k]) begin
			wr(`IMC_OFS_MASK_CLR, 32'h00000001 << bits[k]);
			exp &= ~(32'h00000001 << bits[k]);
			chk32(mask_o, exp, "mask after clear");
			rd(`IMC_OFS_MASK_CLR, exp);
			rd(`IMC_OFS_MASK_SET, exp);
		end
		$display("test_clear_bits done");
	endtask

	// Interrupt qualification per event, gate and mask cleared in the write cycle
	task automatic test_irq;
		logic [31:0] fb;
		for (int i = 0; i < 8; i++) begin
			fb = (i == 7) ? 32'h40000000 : 32'h00000001 << i;
			wr(`IMC_OFS_MASK_SET, 32'hFFFFFFFF);
			pulse(imc_event_type'(8'h01 << i));
			chk1(irq_o, 1'b1, "irq on event");
			rd(`IMC_OFS_FLAGS, fb);
			wr(`IMC_OFS_MASK_CLR, 32'h80000000, 1'b1, 1'b0);
			chk1(irq_o, 1'b0, "irq with gate cleared");
			wr(`IMC_OFS_MASK_SET, 32'h80000000);
			chk1(irq_o, 1'b1, "irq with gate set again");
			wr(`IMC_OFS_MASK_CLR, fb, 1'b1, 1'b0);
			chk1(irq_o, 1'b0, "irq with event masked");
			wr(`IMC_OFS_FLAGS, fb);
			rd(`IMC_OFS_FLAGS, `IMC_FLAGS_RESET);
		end
		$display("test_irq done");
	endtask

	// A flag event in the cycle of its clear keeps the flag and the interrupt
	task automatic test_set_wins;
		imc_event_type ev;
		ev = '0;
		ev.fatal_error = 1'b1;
		pulse(ev);
		@(posedge clock_i);
		bus_i <= '{`IMC_OFS_FLAGS, 32'h00000001 << `IMC_BIT_FATAL, 1'b1, 1'b0};
		event_i <= ev;
		@(posedge clock_i);
		bus_i <= '0;
		event_i <= '0;
		#1;
		chk1(irq_o, 1'b1, "irq kept by event in clear cycle");
		rd(`IMC_OFS_FLAGS, 32'h00000001 << `IMC_BIT_FATAL);
		wr(`IMC_OFS_FLAGS, 32'h00000001 << `IMC_BIT_FATAL);
		rd(`IMC_OFS_FLAGS, `IMC_FLAGS_RESET);
		$display("test_set_wins done");
	endtask

	// Unmapped place, then software and hardware reset in mid-run
	task automatic test_unmapped_and_resets;
		wr(`IMC_OFS_MASK_CLR, `IMC_MASK_BITS);
		wr(8'h20, 32'hFFFFFFFF);
		chk32(mask_o, `IMC_MASK_RESET, "mask after unmapped write");
		rd(8'h20, `IMC_READ_ZERO);
		wr(`IMC_OFS_MASK_SET, 32'hFFFFFFFF);
		@(posedge clock_i);
		soft_reset_i <= 1'b1;
		@(posedge clock_i);
		soft_reset_i <= 1'b0;
		#1;
		chk32(mask_o, `IMC_MASK_RESET, "mask after soft reset");
		wr(`IMC_OFS_MASK_SET, 32'hFFFFFFFF);
		@(posedge clock_i);
		nrst_i <= 1'b0;
		#1;
		chk32(mask_o, `IMC_MASK_RESET, "mask in hardware reset");
		@(posedge clock_i);
		nrst_i <= 1'b1;
		rd(`IMC_OFS_MASK_CLR, `IMC_MASK_RESET);
		$display("test_unmapped_and_resets done");
	endtask

	// Counts and verdict
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		miscompares = 0;
		samples_checked = 0;
		nrst_i = 1'b0;
		soft_reset_i = 1'b0;
		bus_i = '0;
		event_i = '0;
		repeat (10) @(posedge clock_i);
		nrst_i <= 1'b1;
		#1;
		test_reset;
		test_clear_bits;
		test_irq;
		test_set_wins;
		test_unmapped_and_resets;
		print_verdict;
	end

	// Watchdog against a hang
	initial begin
		#40000;
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict;
	end

endmodule

//--- common/imc_map.svh
// Register offsets, field positions and reset values of the interrupt mask block
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH

// Bus widths
`define IMC_ADDR_W        8
`define IMC_DATA_W        32

// Register byte offsets
`define IMC_OFS_FLAGS     8'h0C
`define IMC_OFS_MASK_SET  8'h10
`define IMC_OFS_MASK_CLR  8'h14

// Field positions, common to flags, set port and clear port
`define IMC_BIT_GATE      31
`define IMC_BIT_OWNER     30
`define IMC_BIT_HUB       6
`define IMC_BIT_WRAP      5
`define IMC_BIT_FATAL     4
`define IMC_BIT_WAKE      3
`define IMC_BIT_FRAME     2
`define IMC_BIT_DONE      1
`define IMC_BIT_OVERRUN   0

// Implemented bits; reserved positions 29 to 7 hold no storage
`define IMC_MASK_BITS     32'hC000007F
`define IMC_EVENT_BITS    32'h4000007F

// Reset values
`define IMC_MASK_RESET    32'h00000000
`define IMC_FLAGS_RESET   32'h00000000
`define IMC_READ_ZERO     32'h00000000

`endif

//--- common/imc_pkg.sv
// Types and shared helper of the interrupt mask block
`include "imc_map.svh"

package imc_pkg;

	// One register bus request
	typedef struct packed {
		logic [`IMC_ADDR_W-1:0] addr;
		logic [`IMC_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} imc_bus_req_type;

	// Event pulses from the controller logic
	typedef struct packed {
		logic owner_change;
		logic hub_port_change;
		logic frame_count_wrap;
		logic fatal_error;
		logic wake_detect;
		logic frame_begin;
		logic done_list_written;
		logic schedule_overflow;
	} imc_event_type;

	// Clear then set, limited to the implemented bits; a set beats a clear
	function automatic logic [`IMC_DATA_W-1:0] imc_apply(
		input logic [`IMC_DATA_W-1:0] cur,
		input logic [`IMC_DATA_W-1:0] set,
		input logic [`IMC_DATA_W-1:0] clr,
		input logic [`IMC_DATA_W-1:0] legal
	);
		imc_apply = ((cur & ~clr) | set) & legal;
	endfunction

endpackage

//--- rtl/imc_mask_store.sv
// Shared interrupt mask storage behind the set port and the clear port
`timescale 1ns/1ps
`include "imc_map.svh"

module imc_mask_store
	import imc_pkg::*;
#(
	parameter int WIDTH = `IMC_DATA_W
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	// Control
	input  wire logic             soft_reset_i,
	input  wire logic             set_wr_i,
	input  wire logic             clr_wr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// Live mask
	output logic      [WIDTH-1:0] mask_o
);

	logic [WIDTH-1:0] set_bits;
	logic [WIDTH-1:0] clr_bits;
	logic [WIDTH-1:0] next_mask;

	// Ones written to a port select bits, zeros leave them alone
	assign set_bits = set_wr_i ? wdata_i : '0;                         // R18
	assign clr_bits = clr_wr_i ? wdata_i : '0;                         // R2 R3
	assign next_mask = soft_reset_i ? `IMC_MASK_RESET
	                 : imc_apply(mask_o, set_bits, clr_bits, `IMC_MASK_BITS); // R1 R7

	// Mask register, gate bit starts cleared
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mask_o <= `IMC_MASK_RESET;                                 // R7
		end else begin
			mask_o <= next_mask;
		end
	end

endmodule

//--- rtl/imc_top.sv
// Interrupt mask block: event flags, mask set and clear ports, interrupt request
// Function
// (R1) Clear port bits map one to one onto flag and mask bits.
// (R2) Writing one to a clear port bit clears that mask bit.
// (R3) Writing zero to a clear port bit leaves that mask bit alone.
// (R4) Reading the clear port returns the live mask.
// (R5) Clear port is one 32-bit word at byte offset 14h.
// (R6) Bit 31 clears the global gate, blocking every interrupt.
// (R7) Hardware or software reset leaves the global gate cleared.
// (R8) Bit 30 clears the owner change mask bit.
// (R9) Bit 6 clears the hub port change mask bit.
// (R10) Bit 5 clears the frame count wrap mask bit.
// (R11) Bit 4 clears the fatal error mask bit.
// (R12) Bit 3 clears the wake detect mask bit.
// (R13) Bit 2 clears the frame begin mask bit.
// (R14) Bit 1 clears the done list written mask bit.
// (R15) Bit 0 clears the schedule overflow mask bit.
// (R16) Software writes reserved bits 29 to 7 as zero.
// (R17) Interrupt only when flag, its mask bit and the gate are set.
// (R18) Set port sets bits written one, sharing storage with clear port.
// (R19) A cleared mask bit reads back next and stops interrupts at once.
`timescale 1ns/1ps
`include "imc_map.svh"

module imc_top
	import imc_pkg::*;
(
	// Clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   nrst_i,
	input  wire logic                   soft_reset_i,
	// Register bus
	input  wire imc_bus_req_type        bus_i,
	output logic      [`IMC_DATA_W-1:0] rdata_o,
	// Controller events
	input  wire imc_event_type          event_i,
	// Interrupt and mask view
	output logic                        irq_o,
	output logic      [`IMC_DATA_W-1:0] mask_o
);

	logic                   hit_flags;
	logic                   hit_set;
	logic                   hit_clr;
	logic                   wr_flags;
	logic                   wr_set;
	logic                   wr_clr;
	logic                   rd_any;
	logic [`IMC_DATA_W-1:0] event_word;
	logic [`IMC_DATA_W-1:0] flags;
	logic [`IMC_DATA_W-1:0] next_flags;
	logic [`IMC_DATA_W-1:0] flag_clr;
	logic [`IMC_DATA_W-1:0] mask;
	logic [`IMC_DATA_W-1:0] live_mask;
	logic [`IMC_DATA_W-1:0] read_mux;
	logic [`IMC_DATA_W-1:0] pending;

	// Address decode, one aligned word per register
	assign hit_flags = (bus_i.addr == `IMC_OFS_FLAGS);
	assign hit_set   = (bus_i.addr == `IMC_OFS_MASK_SET);
	assign hit_clr   = (bus_i.addr == `IMC_OFS_MASK_CLR);                // R5
	assign wr_flags  = bus_i.wr && hit_flags;
	assign wr_set    = bus_i.wr && hit_set;                              // R18
	assign wr_clr    = bus_i.wr && hit_clr;                              // R2
	assign rd_any    = bus_i.rd;

	// Event pulses placed at their flag positions
	always_comb begin
		event_word = '0;
		event_word[`IMC_BIT_OWNER]   = event_i.owner_change;             // R1
		event_word[`IMC_BIT_HUB]     = event_i.hub_port_change;
		event_word[`IMC_BIT_WRAP]    = event_i.frame_count_wrap;
		event_word[`IMC_BIT_FATAL]   = event_i.fatal_error;
		event_word[`IMC_BIT_WAKE]    = event_i.wake_detect;
		event_word[`IMC_BIT_FRAME]   = event_i.frame_begin;
		event_word[`IMC_BIT_DONE]    = event_i.done_list_written;
		event_word[`IMC_BIT_OVERRUN] = event_i.schedule_overflow;
	end

	// Sticky flags, write one to clear, a new event beats the clear
	assign flag_clr   = wr_flags ? bus_i.wdata : '0;
	assign next_flags = soft_reset_i ? `IMC_FLAGS_RESET
	                  : imc_apply(flags, event_word, flag_clr, `IMC_EVENT_BITS);

	// Flag register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flags <= `IMC_FLAGS_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	// Shared mask behind both ports; reserved bits are dropped, so zero there is harmless
	imc_mask_store #(
		.WIDTH (`IMC_DATA_W)
	) i_imc_mask_store (
		.clock_i      (clock_i),
		.nrst_i       (nrst_i),
		.soft_reset_i (soft_reset_i),
		.set_wr_i     (wr_set),
		.clr_wr_i     (wr_clr),
		.wdata_i      (bus_i.wdata),
		.mask_o       (mask)
	);                                                                  // R16 R18

	// Each clear port bit knocks out its mask bit in the write cycle itself
	assign live_mask = wr_clr ? (mask & ~bus_i.wdata) : mask;            // R19 R6 R8 R9 R10 R11 R12 R13 R14 R15

	// Qualified interrupt: flag, its mask bit and the gate together
	assign pending = flags & live_mask & `IMC_EVENT_BITS;
	assign irq_o   = live_mask[`IMC_BIT_GATE] && (pending != '0);        // R17 R6

	// Read mux, both mask ports show the live mask, unmapped reads zero
	assign read_mux = hit_flags ? flags
	                : (hit_set || hit_clr) ? mask                        // R4
	                : `IMC_READ_ZERO;

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= `IMC_READ_ZERO;
		end else begin
			rdata_o <= rd_any ? read_mux : `IMC_READ_ZERO;
		end
	end

	// Mask view for the rest of the controller
	assign mask_o = mask;

	// Checks on the mask ports and the interrupt qualification
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	// Storage and flags never hold bits outside the implemented positions
	property p_one_to_one;
		((mask & ~`IMC_MASK_BITS) == '0) && ((flags & ~`IMC_EVENT_BITS) == '0);
	endproperty
	a_one_to_one: assert property (p_one_to_one) // R1
		else $error("mask or flag holds an unimplemented bit");

	// Ones written to the clear port are zero in the mask next cycle
	property p_clear_one;
		wr_clr |=> ((mask & $past(bus_i.wdata)) == '0);
	endproperty
	a_clear_one: assert property (p_clear_one) // R2
		else $error("clear port write left a mask bit set");

	// Zeros written to the clear port keep their mask bits
	property p_clear_zero;
		wr_clr && !soft_reset_i |=> ((mask & ~$past(bus_i.wdata)) == ($past(mask) & ~$past(bus_i.wdata)));
	endproperty
	a_clear_zero: assert property (p_clear_zero) // R3
		else $error("clear port write changed a bit written zero");

	// Clear port read returns the mask as it stood at the strobe
	property p_read_live;
		bus_i.rd && hit_clr |=> (rdata_o == $past(mask));
	endproperty
	a_read_live: assert property (p_read_live) // R4
		else $error("clear port read did not return the live mask");

	// Read data is zero except in the cycle after a read strobe
	property p_read_slot;
		!bus_i.rd |=> (rdata_o == `IMC_READ_ZERO);
	endproperty
	a_read_slot: assert property (p_read_slot) // R5
		else $error("read data outside its slot");

	// Clearing the gate silences the interrupt now and next cycle
	property p_gate_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_GATE] |-> !irq_o ##1 (!irq_o && !mask[`IMC_BIT_GATE]);
	endproperty
	a_gate_clear: assert property (p_gate_clear) // R6
		else $error("gate clear did not block the interrupt");

	// Software reset leaves the gate and every mask bit cleared
	property p_soft_reset;
		soft_reset_i |=> (mask == `IMC_MASK_RESET) && !irq_o;
	endproperty
	a_soft_reset: assert property (p_soft_reset) // R7
		else $error("software reset left the gate open");

	// Owner change mask bit clears through bit 30
	property p_owner_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_OWNER] |=> !mask[`IMC_BIT_OWNER];
	endproperty
	a_owner_clear: assert property (p_owner_clear) // R8
		else $error("owner change mask bit survived its clear");

	// Event mask bits 6 to 0 clear through their own positions
	property p_event_clear;
		wr_clr |=> ((mask[`IMC_BIT_HUB:`IMC_BIT_OVERRUN] & $past(bus_i.wdata[`IMC_BIT_HUB:`IMC_BIT_OVERRUN])) == '0);
	endproperty
	a_event_clear: assert property (p_event_clear) // R9 R10 R11 R12 R13 R14 R15
		else $error("event mask bit survived its clear");

	// An interrupt needs the gate and one flag with its mask bit
	property p_irq_cause;
		irq_o |-> mask[`IMC_BIT_GATE] && ((flags & mask & `IMC_EVENT_BITS) != '0);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // R17
		else $error("interrupt without a qualified flag");

	// Ones written to the set port are present next cycle
	property p_set_one;
		wr_set && !soft_reset_i |=> ((mask & $past(bus_i.wdata) & `IMC_MASK_BITS)
		                              == ($past(bus_i.wdata) & `IMC_MASK_BITS));
	endproperty
	a_set_one: assert property (p_set_one) // R18
		else $error("set port write did not set the mask bit");

	// Clearing every qualifying bit drops the interrupt in the same cycle
	property p_immediate;
		wr_clr && ((flags & mask & `IMC_EVENT_BITS & ~bus_i.wdata) == '0) |-> !irq_o;
	endproperty
	a_immediate: assert property (p_immediate) // R19
		else $error("cleared mask bit still qualified the interrupt");

	// A flag event in its clear cycle is kept
	property p_set_wins;
		wr_flags && event_i.fatal_error && !soft_reset_i |=> flags[`IMC_BIT_FATAL];
	endproperty
	a_set_wins: assert property (p_set_wins) // R1
		else $error("event lost against a flag clear");

	// Every qualified flag raises the interrupt while the gate is set and no clear port write is made
	property p_irq_when_due;
		mask[`IMC_BIT_GATE] && !wr_clr && ((flags & mask & `IMC_EVENT_BITS) != '0) |-> irq_o;
	endproperty
	a_irq_when_due: assert property (p_irq_when_due) // R17
		else $error("qualified flag did not raise the interrupt");

	// A closed gate holds the interrupt low whatever the flags
	property p_gate_low;
		!mask[`IMC_BIT_GATE] |-> !irq_o;
	endproperty
	a_gate_low: assert property (p_gate_low) // R6
		else $error("interrupt raised with the gate closed");

	// Bits written zero to the set port keep their mask value
	property p_set_zero;
		wr_set && !soft_reset_i |=> ((mask & ~$past(bus_i.wdata)) == ($past(mask) & ~$past(bus_i.wdata)));
	endproperty
	a_set_zero: assert property (p_set_zero) // R18
		else $error("set port write changed a bit written zero");

	// Hub port change mask bit clears through bit 6
	property p_hub_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_HUB] |=> !mask[`IMC_BIT_HUB];
	endproperty
	a_hub_clear: assert property (p_hub_clear) // R9
		else $error("hub port change mask bit survived its clear");

	// Frame count wrap mask bit clears through bit 5
	property p_wrap_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_WRAP] |=> !mask[`IMC_BIT_WRAP];
	endproperty
	a_wrap_clear: assert property (p_wrap_clear) // R10
		else $error("frame count wrap mask bit survived its clear");

	// Fatal error mask bit clears through bit 4
	property p_fatal_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_FATAL] |=> !mask[`IMC_BIT_FATAL];
	endproperty
	a_fatal_clear: assert property (p_fatal_clear) // R11
		else $error("fatal error mask bit survived its clear");

	// Wake detect mask bit clears through bit 3
	property p_wake_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_WAKE] |=> !mask[`IMC_BIT_WAKE];
	endproperty
	a_wake_clear: assert property (p_wake_clear) // R12
		else $error("wake detect mask bit survived its clear");

	// Frame begin mask bit clears through bit 2
	property p_frame_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_FRAME] |=> !mask[`IMC_BIT_FRAME];
	endproperty
	a_frame_clear: assert property (p_frame_clear) // R13
		else $error("frame begin mask bit survived its clear");

	// Done list written mask bit clears through bit 1
	property p_done_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_DONE] |=> !mask[`IMC_BIT_DONE];
	endproperty
	a_done_clear: assert property (p_done_clear) // R14
		else $error("done list written mask bit survived its clear");

	// Schedule overflow mask bit clears through bit 0
	property p_overrun_clear;
		wr_clr && bus_i.wdata[`IMC_BIT_OVERRUN] |=> !mask[`IMC_BIT_OVERRUN];
	endproperty
	a_overrun_clear: assert property (p_overrun_clear) // R15
		else $error("schedule overflow mask bit survived its clear");

	// Set port read also returns the mask as it stood at the strobe
	property p_read_set;
		bus_i.rd && hit_set |=> (rdata_o == $past(mask));
	endproperty
	a_read_set: assert property (p_read_set) // R19
		else $error("set port read did not return the live mask");

	// Writes to any other place leave the mask alone
	property p_write_elsewhere;
		bus_i.wr && !hit_set && !hit_clr && !soft_reset_i |=> (mask == $past(mask));
	endproperty
	a_write_elsewhere: assert property (p_write_elsewhere) // R5
		else $error("write outside the mask ports changed the mask");

	// Reads of unmapped places return zero
	property p_read_unmapped;
		bus_i.rd && !hit_flags && !hit_set && !hit_clr |=> (rdata_o == `IMC_READ_ZERO);
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) // R5
		else $error("unmapped read returned data");

	// Flag reads return the flags as they stood at the strobe
	property p_read_flags;
		bus_i.rd && hit_flags |=> (rdata_o == $past(flags));
	endproperty
	a_read_flags: assert property (p_read_flags) // R1
		else $error("flag read did not return the flags");

	// Owner change event lands at bit 30 of the flags
	property p_flag_owner;
		event_i.owner_change && !soft_reset_i |=> flags[`IMC_BIT_OWNER];
	endproperty
	a_flag_owner: assert property (p_flag_owner) // R1
		else $error("owner change event missed its flag");

	// Schedule overflow event lands at bit 0 of the flags
	property p_flag_overrun;
		event_i.schedule_overflow && !soft_reset_i |=> flags[`IMC_BIT_OVERRUN];
	endproperty
	a_flag_overrun: assert property (p_flag_overrun) // R1
		else $error("schedule overflow event missed its flag");

	// Main scenarios
	c_gate_clear_pending: cover property (irq_o ##1 wr_clr && bus_i.wdata[`IMC_BIT_GATE]);
	c_read_clear_port:    cover property (bus_i.rd && hit_clr && (mask != '0));
	c_set_then_clear:     cover property (wr_set ##1 wr_clr);
	c_event_on_clear:     cover property (wr_flags && (event_word != '0));
	c_soft_reset_open:    cover property (soft_reset_i && mask[`IMC_BIT_GATE]);

endmodule
